// ### pfs_pkg.sv
package pfs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned EXT_PG_WAIT_MS  = 10;
    localparam int unsigned EXT_PG_WAIT_CYC = CLK_HZ / 1000 * EXT_PG_WAIT_MS;
    localparam int unsigned HICCUP_WAIT_MS  = 10;
    localparam int unsigned HICCUP_WAIT_CYC = CLK_HZ / 1000 * HICCUP_WAIT_MS;
    localparam int unsigned RST_DLY_UNIT_US = 1000;
    localparam int unsigned RST_DLY_UNIT_CYC =
        CLK_HZ / 1_000_000 * RST_DLY_UNIT_US;
    localparam int unsigned MAX_RETRIES     = 5;

    // ------------------------------------------------------------
    // control field layout
    // ------------------------------------------------------------
    localparam int unsigned CTRL_W          = 8;
    localparam int unsigned RST_DLY_LSB     = 1;
    localparam int unsigned RST_DLY_MSB     = 3;
    localparam int unsigned PROT_MODE_BIT   = 4;
    localparam int unsigned OTP_SEL_LSB     = 6;
    localparam int unsigned OTP_SEL_MSB     = 7;

    localparam logic [1:0] OTP_115C         = 2'h0;
    localparam logic [1:0] OTP_125C         = 2'h1;
    localparam logic [1:0] OTP_135C         = 2'h2;
    localparam logic [1:0] OTP_145C         = 2'h3;
    localparam logic [7:0] TEMP_115C        = 8'h73;
    localparam logic [7:0] TEMP_125C        = 8'h7D;
    localparam logic [7:0] TEMP_135C        = 8'h87;
    localparam logic [7:0] TEMP_145C        = 8'h91;
    localparam logic [7:0] TEMP_HYST        = 8'h14;

    localparam int unsigned N_EVENTS        = 8;
    localparam int unsigned EV_OTP          = 0;

    typedef enum logic { PROT_HICCUP, PROT_LATCH } pfs_prot_t;

    typedef enum {
        ST_OFF, ST_SEQ, ST_EXT_WAIT, ST_RST_DLY,
        ST_ON, ST_HICCUP, ST_LATCHED
    } pfs_state_t;

    typedef struct packed {
        logic [7:0] ev_mask;
        logic [1:0] otp_sel;
        logic       prot_mode;
        logic [2:0] rst_dly;
    } pfs_cfg_t;

    typedef struct packed {
        logic       power_good_reset;
        logic       fault_interrupt_out_n;
        logic       input_overcurrent_flag;
        logic       rails_enable;
        logic [7:0] fault_record;
        logic [2:0] retry_count;
    } pfs_stat_t;

endpackage : pfs_pkg

// ### pfs_thermal_cmp.sv
module pfs_thermal_cmp (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] otp_sel,
    input  wire logic [7:0] die_temp,
    output logic            otp_fault
);
    // ------------------------------------------------------------
    // threshold select
    // ------------------------------------------------------------
    logic [7:0] rise_thr;
    logic [7:0] fall_thr;
    logic       otp_reg;
    logic       otp_next;

    assign rise_thr = (otp_sel == pfs_pkg::OTP_115C) ? pfs_pkg::TEMP_115C :
                      (otp_sel == pfs_pkg::OTP_125C) ? pfs_pkg::TEMP_125C :
                      (otp_sel == pfs_pkg::OTP_135C) ? pfs_pkg::TEMP_135C :
                                                       pfs_pkg::TEMP_145C; // RL13
    assign fall_thr = rise_thr - pfs_pkg::TEMP_HYST;
    // hysteresis keeps the trip from chattering near threshold
    assign otp_next = otp_reg ? (die_temp >= fall_thr)
                              : (die_temp >= rise_thr);
    assign otp_fault = otp_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) otp_reg <= 1'b0;
        else        otp_reg <= otp_next;
    end
endmodule : pfs_thermal_cmp

// ### pfs_supervisor.sv
// How it works
// RL1: power-good reset rises only after every configured rail is up.
// RL2: after power-up, any protection fault shuts down and drops power-good.
// RL3: power-good delay chosen by control bits 3 down to 1.
// RL4: late external regulator counts as last rail, waits up to 10ms.
// RL5: fault interrupt goes low only if shutdown event is in mask.
// RL6: overcurrent flag high above range, operation continues.
// RL7: overcurrent flag returns low when sense drops below range.
// RL8: control bit 4 selects hiccup or latch-off protection.
// RL9: hiccup switches rails off, waits, then restarts power-up.
// RL10: after five failed hiccup retries the device latches off.
// RL11: latch-off mode shuts rails and stays latched.
// RL12: only input re-power above undervoltage threshold leaves latch.
// RL13: thermal trip threshold selectable among 115/125/135/145 C.
// RL14: power-good low in power-up, hiccup, latch; retries cleared on success.
// RL15: host treats power-good low as power loss, reads fault record.
module pfs_supervisor #(
    parameter int unsigned EXT_PG_CYC = pfs_pkg::EXT_PG_WAIT_CYC,
    parameter int unsigned HICCUP_CYC = pfs_pkg::HICCUP_WAIT_CYC,
    parameter int unsigned DLY_UNIT   = pfs_pkg::RST_DLY_UNIT_CYC,
    parameter int unsigned N_EXT      = 3
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [pfs_pkg::CTRL_W-1:0]   ctrl,
    input  wire logic [7:0]                   event_include_mask,
    input  wire logic                         input_undervoltage_threshold,
    input  wire logic                         rails_power_good,
    input  wire logic [N_EXT-1:0]             ext_regulator_used,
    input  wire logic [N_EXT-1:0]             external_regulator_power_good,
    input  wire logic [6:0]                   fault_events,
    input  wire logic [7:0]                   die_temp,
    input  wire logic                         input_current_sense_voltage,
    output pfs_pkg::pfs_stat_t                status
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // every wait runs on one 32-bit counter, so each must fit it
    if (EXT_PG_CYC < 32'h1 || EXT_PG_CYC > 32'h7FFF_FFFF) begin : g_ext_chk
        $error("pfs_supervisor: EXT_PG_CYC out of range");
    end
    if (HICCUP_CYC < 32'h1 || HICCUP_CYC > 32'h7FFF_FFFF) begin : g_hic_chk
        $error("pfs_supervisor: HICCUP_CYC out of range");
    end
    // the longest delay is seven units and must not wrap
    if (DLY_UNIT < 32'h1 || DLY_UNIT > 32'h2492_4924) begin : g_unit_chk
        $error("pfs_supervisor: DLY_UNIT out of range");
    end
    if (N_EXT < 32'h1) begin : g_next_chk
        $error("pfs_supervisor: N_EXT below one");
    end
    // retry count is three bits wide
    if (pfs_pkg::MAX_RETRIES > 32'h7) begin : g_retry_chk
        $error("pfs_supervisor: MAX_RETRIES too large");
    end
    if (pfs_pkg::CTRL_W <= pfs_pkg::OTP_SEL_MSB) begin : g_ctrl_chk
        $error("pfs_supervisor: control word too narrow");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic srst_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign srst_n = rst_s2_reg;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    pfs_pkg::pfs_cfg_t cfg;
    assign cfg.rst_dly   = ctrl[pfs_pkg::RST_DLY_MSB:pfs_pkg::RST_DLY_LSB];
    assign cfg.prot_mode = ctrl[pfs_pkg::PROT_MODE_BIT]; // RL8
    assign cfg.otp_sel   = ctrl[pfs_pkg::OTP_SEL_MSB:pfs_pkg::OTP_SEL_LSB];
    assign cfg.ev_mask   = event_include_mask;

    // ------------------------------------------------------------
    // fault gathering
    // ------------------------------------------------------------
    logic       otp_fault;
    logic [7:0] events;
    logic       any_fault;
    logic       ext_ok;

    pfs_thermal_cmp u_therm (
        .clk       (clk),
        .rst_n     (srst_n),
        .otp_sel   (cfg.otp_sel),
        .die_temp  (die_temp),
        .otp_fault (otp_fault)
    );

    assign events    = {fault_events, otp_fault};
    assign any_fault = |events;
    assign ext_ok    = &(external_regulator_power_good | ~ext_regulator_used);

    // ------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------
    // one counter serves every wait; the states never overlap
    localparam int unsigned CNT_W = 32;

    pfs_pkg::pfs_state_t state_reg;
    pfs_pkg::pfs_state_t state_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic [2:0]          retry_reg;
    logic [2:0]          retry_next;
    logic [7:0]          rec_reg;
    logic [7:0]          rec_next;
    logic                int_n_reg;
    logic                int_n_next;
    logic                pg_reg;
    logic                pg_next;
    logic                ocp_reg;
    logic                uv_prev_reg;
    logic                repower;
    logic [CNT_W-1:0]    dly_cycles;
    logic                latch_now;
    logic                retries_done;

    function automatic logic [CNT_W-1:0] dly_count(input logic [2:0] sel);
        dly_count = CNT_W'(sel) * CNT_W'(DLY_UNIT);
    endfunction : dly_count

    assign dly_cycles   = dly_count(cfg.rst_dly); // RL3
    // latched mode only escapes via a fresh input rise
    assign repower      = input_undervoltage_threshold & ~uv_prev_reg; // RL12
    assign retries_done = (retry_reg >= 3'(pfs_pkg::MAX_RETRIES)); // RL10
    assign latch_now    = (cfg.prot_mode == pfs_pkg::PROT_LATCH) |
                          retries_done; // RL11

    // ------------------------------------------------------------
    // transition decode
    // ------------------------------------------------------------
    // after power-good the retries are already cleared, so only the
    // mode bit picks latch or hiccup there
    function automatic pfs_pkg::pfs_state_t fault_dest(input logic to_latch);
        fault_dest = to_latch ? pfs_pkg::ST_LATCHED : pfs_pkg::ST_HICCUP;
    endfunction : fault_dest

    pfs_pkg::pfs_state_t up_fault_st;
    pfs_pkg::pfs_state_t on_fault_st;
    logic                ext_timeout;
    logic                dly_done;
    logic                hiccup_done;
    logic                int_n_fault;
    logic                input_lost;

    assign up_fault_st = fault_dest(latch_now); // RL10
    assign on_fault_st = fault_dest(cfg.prot_mode == pfs_pkg::PROT_LATCH);
    // a missing external good counts as a failed attempt
    assign ext_timeout = (cnt_reg >= CNT_W'(EXT_PG_CYC)); // RL4
    assign dly_done    = (cnt_reg >= dly_cycles); // RL3
    assign hiccup_done = (cnt_reg >= CNT_W'(HICCUP_CYC) - CNT_W'(1)); // RL9
    // events outside the mask still shut down, just silently
    assign int_n_fault = ~|(events & cfg.ev_mask); // RL5
    assign input_lost  = ~input_undervoltage_threshold; // RL12

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        retry_next = retry_reg;
        rec_next   = rec_reg;
        int_n_next = int_n_reg;
        pg_next    = 1'b0; // RL14
        case (state_reg)
            pfs_pkg::ST_OFF: begin
                if (input_undervoltage_threshold) begin
                    state_next = pfs_pkg::ST_SEQ;
                    int_n_next = 1'b1;
                    rec_next   = '0;
                end
            end
            pfs_pkg::ST_SEQ: begin
                cnt_next = '0;
                if (any_fault) begin
                    rec_next   = events;
                    state_next = up_fault_st;
                end else if (rails_power_good) begin
                    state_next = pfs_pkg::ST_EXT_WAIT;
                end
            end
            pfs_pkg::ST_EXT_WAIT: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (any_fault || ext_timeout) begin // RL4
                    rec_next   = events;
                    state_next = up_fault_st;
                    cnt_next   = '0;
                end else if (ext_ok) begin
                    state_next = pfs_pkg::ST_RST_DLY; // RL4
                    cnt_next   = '0;
                end
            end
            pfs_pkg::ST_RST_DLY: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (any_fault) begin
                    rec_next   = events;
                    state_next = up_fault_st;
                    cnt_next   = '0;
                end else if (dly_done) begin
                    state_next = pfs_pkg::ST_ON; // RL1
                    pg_next    = 1'b1;
                    retry_next = '0; // RL14
                end
            end
            pfs_pkg::ST_ON: begin
                pg_next = 1'b1;
                if (any_fault) begin // RL2
                    pg_next    = 1'b0;
                    rec_next   = events;
                    int_n_next = int_n_fault; // RL5
                    cnt_next   = '0;
                    state_next = on_fault_st; // RL11
                end
            end
            pfs_pkg::ST_HICCUP: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (hiccup_done) begin // RL9
                    cnt_next   = '0;
                    retry_next = retry_reg + 3'h1; // RL10
                    state_next = pfs_pkg::ST_SEQ;
                end
            end
            pfs_pkg::ST_LATCHED: begin
                if (repower) begin // RL12
                    state_next = pfs_pkg::ST_SEQ;
                    retry_next = '0;
                    int_n_next = 1'b1;
                end
            end
            default: state_next = pfs_pkg::ST_OFF;
        endcase
        if (input_lost) begin
            // input gone: rails and pg off, count and retries cleared, latch released on next rise
            state_next = pfs_pkg::ST_OFF;
            pg_next    = 1'b0;
            cnt_next   = '0;
            retry_next = '0;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= pfs_pkg::ST_OFF;
            cnt_reg   <= '0;
            retry_reg <= '0;
            rec_reg   <= '0;
            int_n_reg <= 1'b1;
            pg_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            retry_reg <= retry_next;
            rec_reg   <= rec_next;
            int_n_reg <= int_n_next;
            pg_reg    <= pg_next;
        end
    end

    // ------------------------------------------------------------
    // overcurrent flag and input edge
    // ------------------------------------------------------------
    // flag only reports; it never feeds the fault path
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ocp_reg     <= 1'b0;
            uv_prev_reg <= 1'b1;
        end else begin
            ocp_reg     <= input_current_sense_voltage; // RL6 RL7
            uv_prev_reg <= input_undervoltage_threshold;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign status.power_good_reset       = pg_reg;
    assign status.fault_interrupt_out_n  = int_n_reg;
    assign status.input_overcurrent_flag = ocp_reg;
    // rails follow the state itself so a shutdown costs no extra cycle
    assign status.rails_enable           = (state_reg == pfs_pkg::ST_SEQ) |
                                           (state_reg == pfs_pkg::ST_EXT_WAIT) |
                                           (state_reg == pfs_pkg::ST_RST_DLY) |
                                           (state_reg == pfs_pkg::ST_ON);
    assign status.fault_record           = rec_reg; // RL15
    assign status.retry_count            = retry_reg;
endmodule : pfs_supervisor

// ### pfs_sup_props.sv
module pfs_sup_props (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic [7:0]         ctrl,
    input wire logic [7:0]         event_include_mask,
    input wire logic               input_undervoltage_threshold,
    input wire logic [6:0]         fault_events,
    input wire logic [7:0]         die_temp,
    input wire logic               input_current_sense_voltage,
    input wire pfs_pkg::pfs_stat_t status
);
    // ----
    // helpers
    // ----
    logic [2:0] up_reg;
    logic       pg;
    logic       uv;
    logic [7:0] trip;
    assign pg   = status.power_good_reset;
    assign uv   = input_undervoltage_threshold;
    assign trip = 8'h73 + 8'(ctrl[7:6]) * 8'h0A;
    // edges since release: reset sync hides the first few
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) up_reg <= 3'h0;
        else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // checks
    // ----
    fault_drop_a: assert property (pg && |fault_events |=> !pg)
        else $error("pg kept after fault");
    pg_rails_a: assert property (pg |-> status.rails_enable)
        else $error("pg without rails");
    flag_follow_a: assert property (up_reg == 3'h4 |->
        status.input_overcurrent_flag == $past(input_current_sense_voltage))
        else $error("flag not following sense");
    int_mask_a: assert property ($fell(status.fault_interrupt_out_n) |->
        |(status.fault_record & $past(event_include_mask)))
        else $error("interrupt for excluded event");
    int_set_a: assert property (pg && |(fault_events &
        event_include_mask[7:1]) |=> !status.fault_interrupt_out_n)
        else $error("interrupt missing");
    latch_hold_a: assert property ($fell(pg) && ctrl[4] && uv |->
        !status.rails_enable until !uv)
        else $error("latched device restarted");
    hiccup_off_a: assert property ($fell(pg) && !ctrl[4] && uv |->
        !status.rails_enable [*8])
        else $error("hiccup wait too short");
    retry_max_a: assert property (status.retry_count <= 3'h5)
        else $error("retry count above five");
    retry_clear_a: assert property (pg && $past(pg) |->
        status.retry_count == 3'h0)
        else $error("retry count kept after power-up");
    thermal_trip_a: assert property (pg && die_temp >= trip |->
        ##[1:2] !pg)
        else $error("no thermal shutdown");
    uv_drop_a: assert property (!uv |=> !pg)
        else $error("pg with input low");
    cover property ($fell(pg) && ctrl[4]);
    cover property ($fell(pg) && !ctrl[4]);
    cover property ($rose(status.input_overcurrent_flag));
    cover property (status.retry_count == 3'h5);
endmodule : pfs_sup_props

bind pfs_supervisor pfs_sup_props i_pfs_sup_props (
    .clk                          (clk),
    .rst_n                        (rst_n),
    .ctrl                         (ctrl),
    .event_include_mask           (event_include_mask),
    .input_undervoltage_threshold (input_undervoltage_threshold),
    .fault_events                 (fault_events),
    .die_temp                     (die_temp),
    .input_current_sense_voltage  (input_current_sense_voltage),
    .status                       (status)
);

// ### pfs_host_model.sv
module pfs_host_model (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire pfs_pkg::pfs_stat_t st,
    output logic [7:0]             loss_count
);
    logic pg_q;
    // host sees a pg drop as loss of power
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_q       <= 1'b0;
            loss_count <= 8'h00;
        end else begin
            pg_q <= st.power_good_reset;
            if (pg_q && !st.power_good_reset)
                loss_count <= loss_count + 8'h01;
        end
    end
endmodule : pfs_host_model

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DU = 4;
    logic clk, rst_n, uv, rpg, sense;
    logic [7:0] ctrl, mask, temp, losses;
    logic [2:0] xused, xpg;
    logic [6:0] ev;
    pfs_pkg::pfs_stat_t st;
    int fail_count, n_compared, n, rises;
    logic prev;
    pfs_supervisor #(.EXT_PG_CYC(20), .HICCUP_CYC(10), .DLY_UNIT(DU),
        .N_EXT(3)) i_pfs_supervisor (.clk(clk), .rst_n(rst_n),
        .ctrl(ctrl), .event_include_mask(mask),
        .input_undervoltage_threshold(uv), .rails_power_good(rpg),
        .ext_regulator_used(xused), .external_regulator_power_good(xpg),
        .fault_events(ev), .die_temp(temp),
        .input_current_sense_voltage(sense), .status(st));
    pfs_host_model i_pfs_host_model (.clk(clk), .rst_n(rst_n), .st(st),
        .loss_count(losses));
    // ----
    // helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] exp_up(int d);
        return 8'(4 + DU * d);
    endfunction : exp_up
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // input drop then return above the undervoltage threshold
    task automatic repower;
        uv = 1'b0;
        cyc(3);
        uv = 1'b1;
    endtask : repower
    task automatic up_wait;
        n = 0;
        while (st.power_good_reset !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(negedge clk);
    endtask : up_wait
    task automatic summarize;
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
    // ----
    // scenarios
    // ----
    initial begin
        {rst_n, uv, sense, ev, xused, xpg} = '0;
        rpg = 1'b1;
        ctrl = 8'h00;
        mask = 8'h00;
        temp = 8'h19;
        cyc(5);
        rst_n = 1'b1;
        void'($urandom(17038));
        cyc(3);
        for (int d = 0; d < 8; d++) begin
            ctrl = 8'(d << 1);
            repower();
            up_wait();
            chk("pg_delay", exp_up(d), 8'(n));
        end
        ctrl = 8'h10;
        sense = 1'b1;
        cyc(2);
        chk("oc_flag", 8'h01, 8'(st.input_overcurrent_flag));
        chk("pg_oc", 8'h01, 8'(st.power_good_reset));
        sense = 1'b0;
        cyc(2);
        chk("oc_clear", 8'h00, 8'(st.input_overcurrent_flag));
        for (int i = 0; i < 7; i++) begin
            mask = 8'($urandom);
            repower();
            up_wait();
            chk("pg_repower", exp_up(0), 8'(n));
            ev = 7'(1 << i);
            cyc(1);
            ev = 7'h00;
            cyc(1);
            chk("pg_fault", 8'h00, 8'(st.power_good_reset));
            chk("int_n", 8'(!mask[i+1]), 8'(st.fault_interrupt_out_n));
            chk("record", 8'(2 << i), st.fault_record);
            cyc(20);
            chk("rails_latched", 8'h00, 8'(st.rails_enable));
        end
        mask = 8'h01;
        for (int s = 0; s < 4; s++) begin
            ctrl = 8'(s << 6) | 8'h10;
            repower();
            up_wait();
            temp = 8'(114 + 10 * s);
            cyc(4);
            chk("pg_below_trip", 8'h01, 8'(st.power_good_reset));
            temp = 8'(115 + 10 * s);
            cyc(4);
            chk("pg_trip", 8'h00, 8'(st.power_good_reset));
            chk("int_thermal", 8'h00, 8'(st.fault_interrupt_out_n));
            temp = 8'h19;
        end
        // external regulator never good: every attempt times out
        ctrl = 8'h00;
        xused = 3'h2;
        repower();
        prev = 1'b0;
        rises = 0;
        repeat (600) begin
            cyc(1);
            if (st.rails_enable === 1'b1 && !prev) rises++;
            prev = st.rails_enable;
        end
        chk("attempts", 8'h06, 8'(rises));
        chk("retries", 8'h05, 8'(st.retry_count));
        xpg = 3'h7;
        cyc(50);
        chk("rails_stay_off", 8'h00, 8'(st.rails_enable));
        xpg = 3'h0;
        repower();
        cyc(12);
        chk("pg_ext_wait", 8'h00, 8'(st.power_good_reset));
        xpg = 3'h7;
        up_wait();
        chk("pg_ext_late", 8'h01, 8'(st.power_good_reset));
        chk("retry_clr", 8'h00, 8'(st.retry_count));
        ev = 7'h01;
        cyc(1);
        ev = 7'h00;
        cyc(1);
        chk("pg_hiccup", 8'h00, 8'(st.power_good_reset));
        up_wait();
        chk("hiccup_back", 8'h01, 8'(st.power_good_reset));
        chk("retry_ok", 8'h00, 8'(st.retry_count));
        chk("losses", 8'd20, losses);
        summarize();
    end
endmodule : testbench
